// ---- arc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module arc_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wr;
		logic [AW:0]                 rd;
	} arc_fifo_st_t;

	arc_fifo_st_t s_ff;
	arc_fifo_st_t nxt_s;
	logic         full;
	logic         empty;

	// Extra pointer bit tells full from empty without a counter
	always_comb begin
		nxt_s = s_ff;
		empty = s_ff.wr == s_ff.rd;
		full  = (s_ff.wr[AW] != s_ff.rd[AW]) && (s_ff.wr[AW-1:0] == s_ff.rd[AW-1:0]);
		if (in_valid && !full) begin
			nxt_s.mem[s_ff.wr[AW-1:0]] = in_data;
			nxt_s.wr                   = s_ff.wr + 1'b1;
		end
		if (out_ready && !empty) begin
			nxt_s.rd = s_ff.rd + 1'b1;
		end
	end

	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = s_ff.mem[s_ff.rd[AW-1:0]];

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule : arc_fifo
`default_nettype wire

// ---- arc_pkg.sv ----
`default_nettype none
package arc_pkg;
	// Clock and time base
	localparam int unsigned CLK_NS      = 8;
	localparam int unsigned MS_NS       = 1000000;
	localparam int unsigned MS_CYC      = MS_NS / CLK_NS;
	localparam int unsigned SWP_GAP_NS  = 2500000;
	localparam int unsigned SWP_GAP_CYC = SWP_GAP_NS / CLK_NS;
	localparam int unsigned TICK_W      = 17;
	localparam int unsigned GAP_W       = 19;
	// Limits
	localparam int unsigned MAX_DELAY_MS = 1000000;
	localparam int unsigned MAX_SWEEPS   = 200000;
	localparam int unsigned MAX_PENDING  = 2000;
	localparam int unsigned PCT_FULL     = 100;
	// Widths and depths
	localparam int unsigned DW          = 16;
	localparam int unsigned FIFO_DEPTH  = 8;
	localparam int unsigned SMEM_DEPTH  = 64;
	localparam int unsigned SMEM_AW     = 6;
	localparam int unsigned PTR_W       = SMEM_AW + 1;
	localparam int unsigned LEN_W       = 7;
	localparam int unsigned PCT_W       = 7;
	localparam int unsigned MS_W        = 20;
	localparam int unsigned HIST_W      = 24;
	localparam int unsigned TOTAL_W     = 18;
	localparam int unsigned PEND_W      = 11;
	// Reset values
	localparam logic [DW-1:0] MARK_DATA_RST = 16'h0000;

	typedef enum logic [1:0] {ARC_K_CONT, ARC_K_SWEEP, ARC_K_OVR, ARC_K_TRIG} arc_kind_t;
	typedef enum logic [1:0] {ARC_M_STD, ARC_M_CIRC, ARC_M_TIMED, ARC_M_STOPTRIG} arc_mode_t;
	typedef enum logic [1:0] {ARC_IDLE, ARC_REC, ARC_SUSP} arc_run_t;
	typedef enum logic [1:0] {ARC_SW_OFF, ARC_SW_ARMED, ARC_SW_DELAY, ARC_SW_POST} arc_swp_t;

	typedef struct packed {
		arc_kind_t       kind;
		logic [DW-1:0]   data;
	} arc_word_t;

	typedef struct packed {
		arc_mode_t         mode;
		logic              dual;
		logic              stretch;
		logic [PCT_W-1:0]  pre_pct;
		logic [MS_W-1:0]   delay_ms;
		logic [MS_W-1:0]   dur_ms;
		logic [LEN_W-1:0]  swp_len;
		logic [HIST_W-1:0] hist_words;
	} arc_cfg_t;

	typedef struct packed {
		logic               recording;
		logic               suspended;
		logic               sweep_busy;
		logic [PEND_W-1:0]  pending;
		logic [TOTAL_W-1:0] total;
	} arc_stat_t;
endpackage : arc_pkg
`default_nettype wire

// ---- arc_rec_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Timed mode stops when the duration elapses, or earlier on media full.
// - Stop-on-trigger mode stops on any system trigger, or earlier on media full.
// - Circular mode has no duration limit and records until stopped; the code also ends it on any system trigger.
// - Continuous samples pass through a FIFO when streaming outpaces storage.
// - A full FIFO suspends recording; new samples dropped, draining continues.
// - After suspension, resume only when all internal memory is empty; the code resumes with unclaimed pre-trigger samples still held.
// - Each overrun suspension inserts a marker word into the stored stream.
// - Pre-trigger length is a fraction of sweep length, zero to full.
// - An early trigger truncates pre-trigger to samples actually captured.
// - Trigger delay programmable up to one thousand seconds.
// - After a delay, capture starts at once, whole sweep is post-trigger.
// - At most 200000 sweeps per recording and 2000 pending storage.
// - Sweep capture rate capped at 400 sweeps per second.
// - Re-arm without dead time, but sweeps spaced at least 2.5 ms.
// - With stretch on, a trigger during post-trigger restarts the post count.
// - A retrigger whose stretched post-trigger cannot fit is ignored.
// - At most one stretch honoured every 2.5 ms.
// - Continuous data wins storage bandwidth over sweep data.
// - Sweep storage starts as soon as its trigger is seen.
// - Sweep memory freed only after the whole sweep is stored.
// - Sweeps stored one by one in capture order, oldest first.
// - Circular mode wraps the storage address, overwriting the oldest data.
// - Standard mode runs from start to stop command, or until media full.
module arc_rec_ctrl #(
	parameter int unsigned MS_CYCLES  = arc_pkg::MS_CYC,
	parameter int unsigned GAP_CYCLES = arc_pkg::SWP_GAP_CYC
) (
	input  wire logic                          clock,
	input  wire logic                          rst_b,
	input  wire logic                          start_cmd,
	input  wire logic                          stop_cmd,
	input  wire arc_pkg::arc_cfg_t             cfg,
	input  wire logic                          trig_pin,
	input  wire logic                          media_full_pin,
	input  wire logic                          smp_valid,
	input  wire logic [arc_pkg::DW-1:0]        smp_data,
	output logic                               st_valid,
	output arc_pkg::arc_word_t                 st_word,
	output logic      [arc_pkg::HIST_W-1:0]    st_addr,
	input  wire logic                          st_ready,
	output arc_pkg::arc_stat_t                 stat
);
	typedef struct packed {
		arc_pkg::arc_cfg_t                            cfg;
		arc_pkg::arc_run_t                            run;
		arc_pkg::arc_swp_t                            sw;
		logic                                         trig_s1;
		logic                                         trig_s2;
		logic                                         trig_s3;
		logic                                         full_s1;
		logic                                         full_s2;
		logic [arc_pkg::TICK_W-1:0]                   tick_cnt;
		logic [arc_pkg::MS_W-1:0]                     ms_cnt;
		logic [arc_pkg::MS_W-1:0]                     dly_cnt;
		logic [arc_pkg::GAP_W-1:0]                    gap_cnt;
		logic [arc_pkg::GAP_W-1:0]                    str_cnt;
		logic [arc_pkg::SMEM_DEPTH-1:0][arc_pkg::DW-1:0] mem;
		logic [arc_pkg::PTR_W-1:0]                    wr;
		logic [arc_pkg::PTR_W-1:0]                    rd;
		logic [arc_pkg::PTR_W-1:0]                    free;
		logic [arc_pkg::PTR_W-1:0]                    done;
		logic [arc_pkg::PTR_W-1:0]                    start;
		logic                                         skip_vld;
		logic [arc_pkg::PTR_W-1:0]                    skip_from;
		logic [arc_pkg::PTR_W-1:0]                    skip_to;
		logic [arc_pkg::LEN_W-1:0]                    pre_len;
		logic [arc_pkg::LEN_W-1:0]                    post_cnt;
		logic [arc_pkg::LEN_W-1:0]                    post_full;
		logic [arc_pkg::PEND_W-1:0]                   pend;
		logic [arc_pkg::TOTAL_W-1:0]                  total;
		logic                                         ovr_mark;
		logic                                         trig_mark;
		logic [arc_pkg::HIST_W-1:0]                   addr;
		logic                                         st_valid;
		arc_pkg::arc_word_t                           st_word;
		logic                                         rec;
		logic                                         susp;
		logic                                         busy;
	} arc_st_t;

	arc_st_t                      s_ff;
	arc_st_t                      nxt_s;
	logic                         trig;
	logic                         tick;
	logic                         stop;
	logic                         swp_wr;
	logic                         accept;
	logic [arc_pkg::PTR_W-1:0]    used;
	logic [arc_pkg::PTR_W-1:0]    pre_act;
	logic [arc_pkg::LEN_W-1:0]    post_len;
	logic [arc_pkg::PTR_W-1:0]    rd_eff;
	logic [arc_pkg::PTR_W-1:0]    lim;
	logic [arc_pkg::HIST_W-1:0]   addr_inc;
	logic [arc_pkg::PCT_W-1:0]    pct_sat;
	logic                         cf_in_valid;
	logic                         cf_in_ready;
	logic                         cf_out_valid;
	logic                         cf_out_ready;
	logic [arc_pkg::DW-1:0]       cf_out_data;

	// Room check shared by sweep accept (full sweep length when delayed) and stretch
	function automatic logic fits(
		input logic [arc_pkg::PTR_W-1:0] u,
		input logic [arc_pkg::LEN_W-1:0] len
	);
		logic [arc_pkg::PTR_W:0] sum;
		sum  = {1'b0, u} + {1'b0, len};
		fits = sum <= (arc_pkg::PTR_W+1)'(arc_pkg::SMEM_DEPTH);
	endfunction : fits

	arc_fifo #(
		.WIDTH (arc_pkg::DW),
		.DEPTH (arc_pkg::FIFO_DEPTH)
	) u_cont_fifo (
		.clock     (clock),
		.rst_b     (rst_b),
		.in_valid  (cf_in_valid),
		.in_data   (smp_data),
		.in_ready  (cf_in_ready),
		.out_valid (cf_out_valid),
		.out_data  (cf_out_data),
		.out_ready (cf_out_ready)
	);

	always_comb begin
		nxt_s        = s_ff;
		trig         = s_ff.trig_s2 && !s_ff.trig_s3;
		tick         = s_ff.tick_cnt == '0;
		used         = s_ff.wr - s_ff.free;
		pre_act      = s_ff.wr - s_ff.start;
		post_len     = s_ff.cfg.swp_len - arc_pkg::LEN_W'(pre_act);
		stop         = 1'b0;
		accept       = 1'b0;
		cf_out_ready = 1'b0;
		rd_eff       = s_ff.rd;
		addr_inc     = s_ff.addr + 1'b1;
		pct_sat      = (cfg.pre_pct > arc_pkg::PCT_W'(arc_pkg::PCT_FULL)) ?
		               arc_pkg::PCT_W'(arc_pkg::PCT_FULL) : cfg.pre_pct;

		// Pins pass two flops before any logic looks at them
		nxt_s.trig_s1 = trig_pin;
		nxt_s.trig_s2 = s_ff.trig_s1;
		nxt_s.trig_s3 = s_ff.trig_s2;
		nxt_s.full_s1 = media_full_pin;
		nxt_s.full_s2 = s_ff.full_s1;

		nxt_s.tick_cnt = tick ? arc_pkg::TICK_W'(MS_CYCLES - 1) : s_ff.tick_cnt - 1'b1;
		if (s_ff.gap_cnt != '0) begin
			nxt_s.gap_cnt = s_ff.gap_cnt - 1'b1;
		end
		if (s_ff.str_cnt != '0) begin
			nxt_s.str_cnt = s_ff.str_cnt - 1'b1;
		end

		// Output stage: markers, then continuous, then sweeps
		if (s_ff.st_valid && st_ready) begin
			nxt_s.st_valid = 1'b0;
			if (s_ff.cfg.mode == arc_pkg::ARC_M_CIRC && addr_inc == s_ff.cfg.hist_words) begin
				nxt_s.addr = '0;
			end else begin
				nxt_s.addr = addr_inc;
			end
		end
		if (s_ff.skip_vld && s_ff.rd == s_ff.skip_from) begin
			rd_eff         = s_ff.skip_to;
			nxt_s.rd       = rd_eff;
			nxt_s.skip_vld = 1'b0;
		end
		// Open sweep is readable while still being captured
		lim = (s_ff.sw == arc_pkg::ARC_SW_POST) ? s_ff.wr : s_ff.done;
		if (!nxt_s.st_valid) begin
			nxt_s.st_valid = 1'b1;
			if (s_ff.ovr_mark) begin
				nxt_s.st_word  = {arc_pkg::ARC_K_OVR, arc_pkg::MARK_DATA_RST};
				nxt_s.ovr_mark = 1'b0;
			end else if (s_ff.trig_mark) begin
				nxt_s.st_word   = {arc_pkg::ARC_K_TRIG, s_ff.total[arc_pkg::DW-1:0]};
				nxt_s.trig_mark = 1'b0;
			end else if (cf_out_valid) begin
				nxt_s.st_word = {arc_pkg::ARC_K_CONT, cf_out_data};
				cf_out_ready  = 1'b1;
			end else if (rd_eff != lim) begin
				nxt_s.st_word = {arc_pkg::ARC_K_SWEEP, s_ff.mem[rd_eff[arc_pkg::SMEM_AW-1:0]]};
				nxt_s.rd      = rd_eff + 1'b1;
			end else begin
				nxt_s.st_valid = 1'b0;
			end
		end
		// Memory comes back only once the reader reaches a sweep end
		// Armed history behind the pre-trigger window is dead space, so it is handed back too
		if (nxt_s.rd == s_ff.done) begin
			nxt_s.free = (s_ff.sw == arc_pkg::ARC_SW_ARMED && !s_ff.skip_vld) ? s_ff.start : s_ff.done;
			nxt_s.pend = '0;
		end

		// Continuous recording
		cf_in_valid = smp_valid && s_ff.run == arc_pkg::ARC_REC;
		unique case (s_ff.run)
			arc_pkg::ARC_IDLE: begin
				if (start_cmd) begin
					nxt_s.cfg     = cfg;
					nxt_s.run     = arc_pkg::ARC_REC;
					nxt_s.ms_cnt  = '0;
					nxt_s.total   = '0;
					nxt_s.addr    = '0;
					nxt_s.pre_len = arc_pkg::LEN_W'((cfg.swp_len * pct_sat) / arc_pkg::PCT_FULL);
				end
			end
			arc_pkg::ARC_REC, arc_pkg::ARC_SUSP: begin
				if (tick) begin
					nxt_s.ms_cnt = s_ff.ms_cnt + 1'b1;
				end
				// Circular ignores media full: it overwrites instead
				stop = stop_cmd
				     || (s_ff.cfg.mode != arc_pkg::ARC_M_CIRC && s_ff.full_s2)
				     || (s_ff.cfg.mode == arc_pkg::ARC_M_TIMED && s_ff.ms_cnt >= s_ff.cfg.dur_ms)
				     || (s_ff.cfg.mode == arc_pkg::ARC_M_STOPTRIG && trig)
				     || (s_ff.cfg.mode == arc_pkg::ARC_M_CIRC && trig);
				if (stop) begin
					nxt_s.run = arc_pkg::ARC_IDLE;
				end else if (s_ff.run == arc_pkg::ARC_REC && !cf_in_ready) begin
					nxt_s.run      = arc_pkg::ARC_SUSP;
					nxt_s.ovr_mark = 1'b1;
				// Unclaimed pre-trigger samples are not owed to storage; waiting on them would never end
				end else if (s_ff.run == arc_pkg::ARC_SUSP && !cf_out_valid && s_ff.rd == lim) begin
					nxt_s.run = arc_pkg::ARC_REC;
				end
			end
			default: begin
				nxt_s.run = arc_pkg::ARC_IDLE;
			end
		endcase

		// Sweep capture; no sweep samples are taken while suspended
		swp_wr = smp_valid && s_ff.run == arc_pkg::ARC_REC
		         && used < arc_pkg::PTR_W'(arc_pkg::SMEM_DEPTH)
		         && (s_ff.sw == arc_pkg::ARC_SW_ARMED || s_ff.sw == arc_pkg::ARC_SW_POST);
		if (s_ff.sw == arc_pkg::ARC_SW_ARMED && trig && s_ff.gap_cnt == '0) begin
			// The trigger-cycle sample is kept out of the sweep to keep lengths exact
			swp_wr = 1'b0;
			accept = !s_ff.skip_vld
			         && s_ff.total < arc_pkg::TOTAL_W'(arc_pkg::MAX_SWEEPS)
			         && s_ff.pend < arc_pkg::PEND_W'(arc_pkg::MAX_PENDING)
			         && fits(used, (s_ff.cfg.delay_ms != '0) ? s_ff.cfg.swp_len : post_len);
		end
		if (swp_wr) begin
			nxt_s.mem[s_ff.wr[arc_pkg::SMEM_AW-1:0]] = smp_data;
			nxt_s.wr                                 = s_ff.wr + 1'b1;
		end

		if (s_ff.run == arc_pkg::ARC_IDLE || stop || !s_ff.cfg.dual) begin
			nxt_s.sw = arc_pkg::ARC_SW_OFF;
		end else begin
			unique case (s_ff.sw)
				arc_pkg::ARC_SW_OFF: begin
					nxt_s.sw    = arc_pkg::ARC_SW_ARMED;
					nxt_s.start = s_ff.wr;
				end
				arc_pkg::ARC_SW_ARMED: begin
					if (trig && s_ff.gap_cnt == '0) begin
						if (accept) begin
							nxt_s.total     = s_ff.total + 1'b1;
							nxt_s.gap_cnt   = arc_pkg::GAP_W'(GAP_CYCLES - 1);
							nxt_s.skip_from = s_ff.done;
							if (s_ff.cfg.delay_ms != '0) begin
								nxt_s.sw      = arc_pkg::ARC_SW_DELAY;
								nxt_s.dly_cnt = s_ff.cfg.delay_ms;
							end else if (post_len == '0) begin
								nxt_s.done     = s_ff.wr;
								nxt_s.start    = s_ff.wr;
								nxt_s.pend     = nxt_s.pend + 1'b1;
								nxt_s.skip_to  = s_ff.start;
								nxt_s.skip_vld = 1'b1;
							end else begin
								nxt_s.sw        = arc_pkg::ARC_SW_POST;
								nxt_s.post_cnt  = post_len;
								nxt_s.post_full = post_len;
								nxt_s.skip_to   = s_ff.start;
								nxt_s.skip_vld  = 1'b1;
							end
						end else begin
							// Refused (no room, a sweep or pending limit, or a skip still open): record only that a trigger happened
							nxt_s.trig_mark = 1'b1;
						end
					end else if (swp_wr && pre_act >= arc_pkg::PTR_W'(s_ff.pre_len)) begin
						nxt_s.start = s_ff.start + 1'b1;
					end
				end
				arc_pkg::ARC_SW_DELAY: begin
					if (tick) begin
						if (s_ff.dly_cnt <= arc_pkg::MS_W'(1)) begin
							nxt_s.sw        = arc_pkg::ARC_SW_POST;
							nxt_s.start     = s_ff.wr;
							nxt_s.post_cnt  = s_ff.cfg.swp_len;
							nxt_s.post_full = s_ff.cfg.swp_len;
							nxt_s.skip_to   = s_ff.wr;
							nxt_s.skip_vld  = 1'b1;
						end else begin
							nxt_s.dly_cnt = s_ff.dly_cnt - 1'b1;
						end
					end
				end
				arc_pkg::ARC_SW_POST: begin
					if (trig && s_ff.cfg.stretch && s_ff.str_cnt == '0 && fits(used, s_ff.post_full)) begin
						nxt_s.post_cnt = s_ff.post_full;
						nxt_s.str_cnt  = arc_pkg::GAP_W'(GAP_CYCLES - 1);
					end else if (swp_wr) begin
						if (s_ff.post_cnt <= arc_pkg::LEN_W'(1)) begin
							// Zero re-arm: next pre-trigger starts on the very next sample
							nxt_s.sw    = arc_pkg::ARC_SW_ARMED;
							nxt_s.done  = s_ff.wr + 1'b1;
							nxt_s.start = s_ff.wr + 1'b1;
							nxt_s.pend  = nxt_s.pend + 1'b1;
						end else begin
							nxt_s.post_cnt = s_ff.post_cnt - 1'b1;
						end
					end
				end
			endcase
		end

		// Status bits are registered copies so every output leaves a flop
		nxt_s.rec  = nxt_s.run != arc_pkg::ARC_IDLE;
		nxt_s.susp = nxt_s.run == arc_pkg::ARC_SUSP;
		nxt_s.busy = nxt_s.sw != arc_pkg::ARC_SW_OFF;
	end

	assign st_valid        = s_ff.st_valid;
	assign st_word         = s_ff.st_word;
	assign st_addr         = s_ff.addr;
	assign stat.recording  = s_ff.rec;
	assign stat.suspended  = s_ff.susp;
	assign stat.sweep_busy = s_ff.busy;
	assign stat.pending    = s_ff.pend;
	assign stat.total      = s_ff.total;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule : arc_rec_ctrl
`default_nettype wire

// ---- arc_rec_ctrl_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module arc_rec_ctrl_chk #(
	parameter int unsigned MS_CYCLES  = arc_pkg::MS_CYC,
	parameter int unsigned GAP_CYCLES = arc_pkg::SWP_GAP_CYC
) (
	input wire logic                       clock,
	input wire logic                       rst_b,
	input wire logic                       start_cmd,
	input wire logic                       stop_cmd,
	input wire arc_pkg::arc_cfg_t          cfg,
	input wire logic                       trig_pin,
	input wire logic                       media_full_pin,
	input wire logic                       st_valid,
	input wire arc_pkg::arc_word_t         st_word,
	input wire logic [arc_pkg::HIST_W-1:0] st_addr,
	input wire logic                       st_ready,
	input wire arc_pkg::arc_stat_t         stat
);
	logic [arc_pkg::TOTAL_W-1:0] tot_ff;
	logic [arc_pkg::GAP_W-1:0]   gap_ff;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	// Cycles since the sweep count last moved; saturates so long idle spans never wrap
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tot_ff <= '0;
			gap_ff <= '1;
		end else begin
			tot_ff <= stat.total;
			gap_ff <= (stat.total != tot_ff) ? arc_pkg::GAP_W'(1) : gap_ff + arc_pkg::GAP_W'(gap_ff != '1);
		end
	end
	property p_hold;
		st_valid && !st_ready |=> st_valid && $stable(st_word) && $stable(st_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("word changed before accept");
	property p_addr;
		st_valid && st_ready |=> st_addr == $past(st_addr) + 24'h000001 || st_addr == 24'h000000;
	endproperty
	a_addr: assert property (p_addr) else $error("address did not step");
	property p_start;
		start_cmd && !stat.recording && !stat.suspended |=> stat.recording;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_stop;
		stop_cmd && stat.recording |=> !stat.recording;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");
	property p_full;
		$rose(media_full_pin) && stat.recording && cfg.mode != arc_pkg::ARC_M_CIRC |-> ##[1:5] !stat.recording;
	endproperty
	a_full: assert property (p_full) else $error("media full did not stop");
	property p_trig;
		$rose(trig_pin) && stat.recording && cfg.mode == arc_pkg::ARC_M_STOPTRIG |-> ##[1:5] !stat.recording;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger did not stop");
	property p_circ;
		(!trig_pin && !stop_cmd)[*5] ##0 (stat.recording && cfg.mode == arc_pkg::ARC_M_CIRC && media_full_pin)
			|=> stat.recording;
	endproperty
	a_circ: assert property (p_circ) else $error("circular run ended");
	property p_mark;
		st_valid && st_word.kind == arc_pkg::ARC_K_OVR |-> st_word.data == 16'h0000;
	endproperty
	a_mark: assert property (p_mark) else $error("marker data not zero");
	property p_susp;
		$rose(stat.suspended) |-> ##[0:40] (st_valid && st_word.kind == arc_pkg::ARC_K_OVR);
	endproperty
	a_susp: assert property (p_susp) else $error("no overrun marker");
	property p_gap;
		stat.total > tot_ff && tot_ff != '0 |-> gap_ff >= GAP_CYCLES;
	endproperty
	a_gap: assert property (p_gap) else $error("sweeps too close");
	property p_lim;
		stat.pending <= arc_pkg::MAX_PENDING && stat.total <= arc_pkg::MAX_SWEEPS;
	endproperty
	a_lim: assert property (p_lim) else $error("sweep count limit passed");
	c_susp: cover property ($rose(stat.suspended));
	c_sweep: cover property (st_valid && st_ready && st_word.kind == arc_pkg::ARC_K_SWEEP);
	c_wrap: cover property (st_valid && st_ready && cfg.mode == arc_pkg::ARC_M_CIRC ##1 st_addr == 24'h000000);
endmodule : arc_rec_ctrl_chk
bind arc_rec_ctrl arc_rec_ctrl_chk #(.MS_CYCLES(MS_CYCLES), .GAP_CYCLES(GAP_CYCLES)) chk (
	.clock, .rst_b, .start_cmd, .stop_cmd, .cfg, .trig_pin, .media_full_pin,
	.st_valid, .st_word, .st_addr, .st_ready, .stat
);
`default_nettype wire

// ---- arc_store_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module arc_store_model (
	input  wire logic                       clock,
	input  wire logic                       rst_b,
	input  wire logic                       stall,
	input  wire logic                       slow,
	input  wire logic                       full_req,
	input  wire logic                       st_valid,
	input  wire arc_pkg::arc_word_t         st_word,
	input  wire logic [arc_pkg::HIST_W-1:0] st_addr,
	output logic                            st_ready,
	output logic                            media_full_pin
);
	arc_pkg::arc_word_t         got_w[$];
	logic [arc_pkg::HIST_W-1:0] got_a[$];
	logic                       pace_ff;
	// Slow pace accepts every other cycle, like a busy link
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_ready       <= 1'b0;
			media_full_pin <= 1'b0;
			pace_ff        <= 1'b0;
		end else begin
			if (st_valid && st_ready) begin
				got_w.push_back(st_word);
				got_a.push_back(st_addr);
			end
			pace_ff        <= ~pace_ff;
			st_ready       <= ~stall & (~slow | pace_ff);
			media_full_pin <= full_req;
		end
	end
endmodule : arc_store_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                        clock;
	logic                        rst_b;
	logic                        start_cmd;
	logic                        stop_cmd;
	arc_pkg::arc_cfg_t           cfg;
	logic                        trig_pin;
	logic                        media_full_pin;
	logic                        smp_valid;
	logic [15:0]                 smp_data;
	logic                        st_valid;
	arc_pkg::arc_word_t          st_word;
	logic [arc_pkg::HIST_W-1:0]  st_addr;
	logic                        st_ready;
	arc_pkg::arc_stat_t          stat;
	logic                        stall;
	logic                        slow;
	logic                        full_req;
	logic [arc_pkg::TOTAL_W-1:0] t0;
	logic [arc_pkg::HIST_W-1:0]  e;
	int                          bad_count;
	int                          tests_run;
	int                          cyc;
	int                          k;
	int                          m;
	arc_rec_ctrl #(.MS_CYCLES(10), .GAP_CYCLES(20)) uut (
		.clock, .rst_b, .start_cmd, .stop_cmd, .cfg, .trig_pin, .media_full_pin,
		.smp_valid, .smp_data, .st_valid, .st_word, .st_addr, .st_ready, .stat
	);
	arc_store_model mdl (
		.clock, .rst_b, .stall, .slow, .full_req, .st_valid, .st_word, .st_addr, .st_ready, .media_full_pin
	);
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick
	task automatic start(input arc_pkg::arc_mode_t md, input logic dl, input logic [6:0] pct);
		tick(20);
		cfg.mode = md;
		cfg.dual = dl;
		cfg.pre_pct = pct;
		start_cmd = 1'b1;
		tick(1);
		start_cmd = 1'b0;
		mdl.got_w.delete();
		mdl.got_a.delete();
		tick(1);
	endtask : start
	task automatic stop;
		stop_cmd = 1'b1;
		tick(1);
		stop_cmd = 1'b0;
		tick(1);
	endtask : stop
	task automatic send(input int n, input logic [15:0] b);
		for (int i = 0; i < n; i++) begin
			smp_valid = 1'b1;
			smp_data = b + 16'(i);
			tick(1);
		end
		smp_valid = 1'b0;
	endtask : send
	task automatic pulse;
		trig_pin = 1'b1;
		tick(2);
		trig_pin = 1'b0;
	endtask : pulse
	// Sweep of four samples; npre samples precede the trigger, so short runs truncate the pre part
	task automatic sweep(input int pct, input int npre, input logic [15:0] b);
		int pl;
		pl = (pct * 4 / 100 < npre) ? pct * 4 / 100 : npre;
		start(arc_pkg::ARC_M_STD, 1'b1, 7'(pct));
		tick(4);
		send(npre, b);
		tick(8);
		t0 = stat.total;
		pulse();
		tick(8);
		send(4, b + 16'(npre));
		tick(30);
		chk(32'(stat.total), 32'(t0) + 32'h1);
		k = 0;
		foreach (mdl.got_w[i]) begin
			if (mdl.got_w[i].kind === arc_pkg::ARC_K_SWEEP) begin
				chk(32'(mdl.got_w[i].data), 32'(b) + 32'(npre - pl + k));
				k++;
			end
		end
		chk(32'(k), 32'h4);
		chk(32'(stat.pending), 32'h0);
		stop();
	endtask : sweep
	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		start_cmd = 1'b0;
		stop_cmd = 1'b0;
		cfg = '0;
		cfg.swp_len = 7'h04;
		cfg.dur_ms = 20'h00003;
		cfg.hist_words = 24'h000003;
		trig_pin = 1'b0;
		smp_valid = 1'b0;
		smp_data = 16'h0000;
		stall = 1'b0;
		slow = 1'b0;
		full_req = 1'b0;
		tick(5);
		rst_b = 1'b1;
		start(arc_pkg::ARC_M_STD, 1'b0, 7'h00);
		chk(32'(stat.recording), 32'h1);
		send(4, 16'h0010);
		pulse();
		tick(12);
		chk(32'(stat.recording), 32'h1);
		chk(32'(mdl.got_w.size()), 32'h4);
		foreach (mdl.got_w[i]) begin
			chk(32'(mdl.got_w[i]), 32'h10 + 32'(i));
			chk(32'(mdl.got_a[i]), 32'(i));
		end
		stop();
		chk(32'(stat.recording), 32'h0);
		start(arc_pkg::ARC_M_STD, 1'b0, 7'h00);
		stall = 1'b1;
		send(12, 16'h0100);
		tick(2);
		chk(32'(stat.suspended), 32'h1);
		stall = 1'b0;
		for (int n = 0; n < 100 && stat.suspended !== 1'b0; n++) tick(1);
		chk(32'(stat.suspended), 32'h0);
		send(2, 16'h0200);
		tick(20);
		k = 0;
		m = 0;
		foreach (mdl.got_w[i]) begin
			if (mdl.got_w[i].kind === arc_pkg::ARC_K_OVR) m++;
			if (mdl.got_w[i].kind === arc_pkg::ARC_K_CONT && mdl.got_w[i].data < 16'h0200) begin
				chk(32'(mdl.got_w[i].data), 32'h100 + 32'(k));
				k++;
			end
		end
		chk(32'(m), 32'h1);
		chk(32'(k >= 8 && k < 12), 32'h1);
		chk(32'(mdl.got_w[$]), 32'h201);
		stop();
		start(arc_pkg::ARC_M_TIMED, 1'b0, 7'h00);
		cfg.dur_ms = 20'h00000;
		tick(12);
		chk(32'(stat.recording), 32'h1);
		tick(40);
		chk(32'(stat.recording), 32'h0);
		cfg.dur_ms = 20'h00003;
		start(arc_pkg::ARC_M_TIMED, 1'b0, 7'h00);
		full_req = 1'b1;
		tick(8);
		chk(32'(stat.recording), 32'h0);
		full_req = 1'b0;
		start(arc_pkg::ARC_M_STOPTRIG, 1'b0, 7'h00);
		pulse();
		tick(8);
		chk(32'(stat.recording), 32'h0);
		start(arc_pkg::ARC_M_CIRC, 1'b0, 7'h00);
		full_req = 1'b1;
		send(5, 16'h0300);
		tick(20);
		chk(32'(stat.recording), 32'h1);
		e = mdl.got_a[0];
		foreach (mdl.got_a[i]) begin
			chk(32'(mdl.got_a[i]), 32'(e));
			e = (e == 24'h000002) ? 24'h000000 : e + 24'h000001;
		end
		full_req = 1'b0;
		stop();
		slow = 1'b1;
		sweep(50, 6, 16'h0400);
		sweep(100, 1, 16'h0410);
		sweep(0, 3, 16'h0420);
		slow = 1'b0;
		start(arc_pkg::ARC_M_STD, 1'b1, 7'h00);
		tick(4);
		t0 = stat.total;
		pulse();
		tick(4);
		send(4, 16'h0500);
		pulse();
		tick(8);
		chk(32'(stat.total), 32'(t0) + 32'h1);
		tick(16);
		pulse();
		tick(8);
		chk(32'(stat.total), 32'(t0) + 32'h2);
		send(4, 16'h0600);
		stop();
		// Delayed sweep: samples before expiry stay out, the whole sweep is post-trigger
		cfg.delay_ms = 20'h00001;
		start(arc_pkg::ARC_M_STD, 1'b1, 7'h32);
		send(3, 16'h0700);
		pulse();
		tick(14);
		send(4, 16'h0710);
		tick(30);
		k = 0;
		foreach (mdl.got_w[i]) begin
			if (mdl.got_w[i].kind === arc_pkg::ARC_K_SWEEP) begin
				chk(32'(mdl.got_w[i].data), 32'h710 + 32'(k));
				k++;
			end
		end
		chk(32'(k), 32'h4);
		stop();
		end_sim();
	end
endmodule : tb
`default_nettype wire
